/* File: rtl/fmg_defs.svh */
// Purpose: constants for the fix mode and output gating block
// Assumes: 20 MHz clock, Wishbone byte addresses, 8-bit mask fields
// Notes:   values are used by the top module only; the screen includes none of them
`ifndef FMG_DEFS_SVH
`define FMG_DEFS_SVH
`define FMG_ADR_CTRL    8'h00
`define FMG_ADR_MASK    8'h04
`define FMG_ADR_ALT     8'h08
`define FMG_ADR_STAT    8'h0C
`define FMG_CTRL_FIX    0
`define FMG_CTRL_DIFF   2
`define FMG_CTRL_PSAVE  4
`define FMG_MASK_ELEV   0
`define FMG_MASK_SNR    8
`define FMG_MASK_DOP    16
`define FMG_MASK_SW     24
`define FMG_ALT_VALID   16
`define FMG_RST_ELEV    8'h05
`define FMG_RST_SNR     8'h02
`define FMG_RST_DOP     8'h0C
`define FMG_RST_SW      8'h05
`define FMG_EPOCH_MS    1000
`define FMG_CLK_KHZ     20000
`define FMG_MIN_2D      4'h3
`define FMG_MIN_3D      4'h4
`endif

/* File: rtl/fmg_pkg.sv */
// Purpose: types and shared functions of the fix mode block
// Assumes: fmg_defs.svh holds the addresses, field positions and thresholds; enum codes are set here
// Notes:   enum codes double as register field encodings
package fmg_pkg;
   typedef enum logic [1:0] {
      FMG_FORCED_TWO_DIM_FIX   = 2'h0,
      FMG_FORCED_THREE_DIM_FIX = 2'h1,
      FMG_AUTO_DIM_FIX         = 2'h2
   } fmg_fix_mode_t;
   typedef enum logic [1:0] {
      FMG_CORRECTION_FORCED_ON  = 2'h0,
      FMG_CORRECTION_FORCED_OFF = 2'h1,
      FMG_CORRECTION_AUTO       = 2'h2
   } fmg_diff_mode_t;
   typedef enum logic [2:0] {
      FMG_NO_FIX    = 3'h1,
      FMG_FIX_2D    = 3'h2,
      FMG_FIX_3D    = 3'h4
   } fmg_fix_state_t;
   // population count of a channel vector, saturating at 15
   function automatic logic [3:0] fmg_popcount(input logic [15:0] v);
      logic [4:0] s;
      s = 5'h00;
      for (int i = 0; i < 16; i++) begin
         s = s + {4'h0, v[i]};
      end
      return (s > 5'h0F) ? 4'hF : s[3:0];
   endfunction
   // merge write data under byte enables
   function automatic logic [31:0] fmg_wmerge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction
endpackage

/* File: rtl/fmg_sat_screen.sv */
// Purpose: screens tracked channels against elevation and signal masks
// Assumes: one entry per channel, flattened 8-bit fields, N up to 16
// Notes:   purely combinational; the top samples it at each epoch and on status register reads
`timescale 1ns/1ps
`default_nettype none
module fmg_sat_screen #(
   parameter int N = 8
) (
   // per channel state
   input  wire logic [N*8-1:0] elev_in,
   input  wire logic [N*8-1:0] snr_in,
   input  wire logic [N-1:0]   locked_in,
   input  wire logic [N-1:0]   eph_valid_in,
   input  wire logic [N-1:0]   corr_valid_in,
   // masks
   input  wire logic [7:0]     elev_mask_in,
   input  wire logic [7:0]     snr_mask_in,
   // results
   output logic      [N-1:0]   qual_out,
   output logic      [3:0]     nq_out,
   output logic      [3:0]     nc_out,
   output logic                eph_ok_out
);
   import fmg_pkg::*;
   logic [15:0] qv;
   logic [15:0] cv;

   // a channel qualifies only when locked and at or above both masks at once
   always_comb begin
      qv = 16'h0000;
      cv = 16'h0000;
      for (int i = 0; i < N; i++) begin
         qv[i] = locked_in[i] && (elev_in[i*8 +: 8] >= elev_mask_in)
                 && (snr_in[i*8 +: 8] >= snr_mask_in);
         cv[i] = qv[i] && corr_valid_in[i];
      end
   end

   assign qual_out   = qv[N-1:0];
   assign nq_out     = fmg_popcount(qv);
   assign nc_out     = fmg_popcount(cv);
   // every used satellite needs orbital data before any report
   assign eph_ok_out = ((qv[N-1:0] & ~eph_valid_in) == '0);
endmodule
`default_nettype wire

/* File: rtl/fmg_top.sv */
// Purpose: fix mode decision and report gating, Wishbone register slave
// Assumes: solver supplies dilution and altitude of the current epoch
// Notes:   decision taken once per epoch; all state frozen while ce_in low
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "fmg_defs.svh"
module fmg_top #(
   parameter int N            = 8,
   parameter int EPOCH_CYCLES = `FMG_EPOCH_MS * `FMG_CLK_KHZ
) (
   // clock and reset
   input  wire logic                    mclk_in,
   input  wire logic                    rstn_in,
   input  wire logic                    ce_in,
   // wishbone slave
   input  wire logic                    wb_cyc_in,
   input  wire logic                    wb_stb_in,
   input  wire logic                    wb_we_in,
   input  wire logic [7:0]              wb_adr_in,
   input  wire logic [3:0]              wb_sel_in,
   input  wire logic [31:0]             wb_dat_in,
   output logic      [31:0]             wb_dat_out,
   output logic                         wb_ack_out,
   // tracking channels
   input  wire logic [N*8-1:0]          sat_elev_in,
   input  wire logic [N*8-1:0]          sat_snr_in,
   input  wire logic [N-1:0]            sat_locked_in,
   input  wire logic [N-1:0]            sat_eph_valid_in,
   input  wire logic [N-1:0]            sat_corr_valid_in,
   // solver and correction source
   input  wire logic                    corr_data_ok_in,
   input  wire logic [7:0]              pdop_in,
   input  wire logic [7:0]              hdop_in,
   input  wire logic [15:0]             alt_fix_in,
   // report outputs
   output logic                         report_valid_out,
   output logic                         fix_three_dim_out,
   output logic                         corrected_out,
   output logic      [15:0]             altitude_out,
   output logic      [N-1:0]            sat_used_out
);
   import fmg_pkg::*;
   localparam int CNT_W = $clog2(EPOCH_CYCLES + 1);

   fmg_fix_mode_t  fix_mode_q;
   fmg_diff_mode_t diff_mode_q;
   fmg_fix_state_t fix_d;
   fmg_fix_state_t fix_q;
   logic             psave_q;
   logic [7:0]       elev_mask_q;
   logic [7:0]       snr_mask_q;
   logic [7:0]       dop_mask_q;
   logic [7:0]       sw_thr_q;
   logic [15:0]      host_alt_q;
   logic             host_alt_ok_q;
   logic [15:0]      last_alt_q;
   logic             last_alt_ok_q;
   logic [CNT_W-1:0] cnt_q;
   logic             epoch_go;
   logic [N-1:0]     qual;
   logic [3:0]       nq;
   logic [3:0]       nc;
   logic             eph_ok;
   logic [3:0]       nsel;
   logic             use_corr;
   logic             allow;
   logic [15:0]      alt_d;
   logic             emit;
   logic             wb_req;
   logic [31:0]      ctrl_rd;
   logic [31:0]      mask_rd;
   logic [31:0]      alt_rd;
   logic [31:0]      stat_rd;
   logic [31:0]      wm;

   fmg_sat_screen #(.N(N)) u_screen (
      .elev_in       (sat_elev_in),
      .snr_in        (sat_snr_in),
      .locked_in     (sat_locked_in),
      .eph_valid_in  (sat_eph_valid_in),
      .corr_valid_in (sat_corr_valid_in),
      .elev_mask_in  (elev_mask_q),
      .snr_mask_in   (snr_mask_q),
      .qual_out      (qual),
      .nq_out        (nq),
      .nc_out        (nc),
      .eph_ok_out    (eph_ok)
   );

   // register views
   assign ctrl_rd = {27'h0, psave_q, diff_mode_q, fix_mode_q};
   assign mask_rd = {sw_thr_q, dop_mask_q, snr_mask_q, elev_mask_q};
   assign alt_rd  = {15'h0, host_alt_ok_q, host_alt_q};
   assign stat_rd = {18'h0, eph_ok, last_alt_ok_q, corrected_out,
                     fix_q, nc, nq};
   assign wb_req  = wb_cyc_in && wb_stb_in && !wb_ack_out;

   // ack one cycle after the request, dropped the next cycle
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wb_ack_out <= 1'b0;
      end else if (ce_in) begin
         wb_ack_out <= wb_req;
      end
   end

   // read data; unmapped addresses read as zero
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wb_dat_out <= 32'h0000_0000;
      end else if (ce_in && wb_req) begin
         case (wb_adr_in)
            `FMG_ADR_CTRL: wb_dat_out <= ctrl_rd;
            `FMG_ADR_MASK: wb_dat_out <= mask_rd;
            `FMG_ADR_ALT:  wb_dat_out <= alt_rd;
            `FMG_ADR_STAT: wb_dat_out <= stat_rd;
            default:       wb_dat_out <= 32'h0000_0000;
         endcase
      end
   end

   // configuration writes, byte lanes honoured
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         fix_mode_q  <= FMG_AUTO_DIM_FIX;
         diff_mode_q <= FMG_CORRECTION_AUTO;
         psave_q     <= 1'b0;
         elev_mask_q <= `FMG_RST_ELEV;
         snr_mask_q  <= `FMG_RST_SNR;
         dop_mask_q  <= `FMG_RST_DOP;
         sw_thr_q    <= `FMG_RST_SW;
         host_alt_q    <= 16'h0000;
         host_alt_ok_q <= 1'b0;
      end else if (ce_in && wb_req && wb_we_in) begin
         case (wb_adr_in)
            `FMG_ADR_CTRL: begin
               fix_mode_q  <= fmg_fix_mode_t'(wm[`FMG_CTRL_FIX +: 2]);
               diff_mode_q <= fmg_diff_mode_t'(wm[`FMG_CTRL_DIFF +: 2]);
               psave_q     <= wm[`FMG_CTRL_PSAVE];
            end
            `FMG_ADR_MASK: begin
               elev_mask_q <= wm[`FMG_MASK_ELEV +: 8];
               snr_mask_q  <= wm[`FMG_MASK_SNR +: 8];
               dop_mask_q  <= wm[`FMG_MASK_DOP +: 8];
               sw_thr_q    <= wm[`FMG_MASK_SW +: 8];
            end
            `FMG_ADR_ALT: begin
               host_alt_q    <= wm[15:0];
               host_alt_ok_q <= wm[`FMG_ALT_VALID];
            end
            default: begin
               host_alt_q <= host_alt_q;
            end
         endcase
      end
   end

   // merged write word for the addressed register
   always_comb begin
      case (wb_adr_in)
         `FMG_ADR_CTRL: wm = fmg_wmerge(ctrl_rd, wb_dat_in, wb_sel_in);
         `FMG_ADR_MASK: wm = fmg_wmerge(mask_rd, wb_dat_in, wb_sel_in);
         `FMG_ADR_ALT:  wm = fmg_wmerge(alt_rd, wb_dat_in, wb_sel_in);
         default:       wm = 32'h0000_0000;
      endcase
   end

   // epoch timer, one decision per second
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cnt_q <= '0;
      end else if (ce_in) begin
         cnt_q <= epoch_go ? '0 : cnt_q + CNT_W'(1);
      end
   end
   assign epoch_go = ce_in && (cnt_q == CNT_W'(EPOCH_CYCLES - 1));

   // correction mode picks which satellite count the fix may use
   always_comb begin
      case (diff_mode_q)
         FMG_CORRECTION_FORCED_ON: begin
            use_corr = 1'b1;
            nsel     = nc;
            allow    = corr_data_ok_in;
         end
         FMG_CORRECTION_FORCED_OFF: begin
            use_corr = 1'b0;
            nsel     = nq;
            allow    = 1'b1;
         end
         default: begin
            // fall back when corrections cannot cover a fix-sized set
            use_corr = corr_data_ok_in && (nc >= `FMG_MIN_2D);
            nsel     = use_corr ? nc : nq;
            allow    = 1'b1;
         end
      endcase
   end

   // fix dimension and the altitude a 2D solution is pinned to
   always_comb begin
      fix_d = FMG_NO_FIX;
      alt_d = alt_fix_in;
      case (fix_mode_q)
         FMG_FORCED_TWO_DIM_FIX: begin
            // switch threshold plays no part here
            if (nsel >= `FMG_MIN_2D && hdop_in < dop_mask_q) begin
               fix_d = FMG_FIX_2D;
               alt_d = host_alt_ok_q ? host_alt_q : 16'h0000;
            end
         end
         FMG_FORCED_THREE_DIM_FIX: begin
            if (nsel >= `FMG_MIN_3D && pdop_in <= dop_mask_q) begin
               fix_d = FMG_FIX_3D;
            end
         end
         default: begin
            if (nsel >= `FMG_MIN_3D && pdop_in <= dop_mask_q
                && pdop_in <= sw_thr_q) begin
               fix_d = FMG_FIX_3D;
            end else if (nsel >= `FMG_MIN_2D && hdop_in < dop_mask_q) begin
               fix_d = FMG_FIX_2D;
               alt_d = last_alt_ok_q ? last_alt_q : 16'h0000;
            end else if (nsel >= `FMG_MIN_3D && pdop_in <= dop_mask_q) begin
               fix_d = FMG_FIX_3D; // 2D geometry failed, 3D still in mask
            end
         end
      endcase
   end

   // nothing leaves unless every active mask and the data gate agree
   assign emit = allow && eph_ok && (fix_d != FMG_NO_FIX) && !psave_q;

   // report registers; the valid pulse is rewritten every enabled cycle, the rest load only at the epoch
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         report_valid_out  <= 1'b0;
         fix_three_dim_out <= 1'b0;
         corrected_out     <= 1'b0;
         altitude_out      <= 16'h0000;
         sat_used_out      <= '0;
         fix_q             <= FMG_NO_FIX;
      end else if (ce_in) begin
         report_valid_out <= epoch_go && emit;
         if (epoch_go) begin
            fix_q <= emit ? fix_d : FMG_NO_FIX;
            if (emit) begin
               fix_three_dim_out <= (fix_d == FMG_FIX_3D);
               corrected_out     <= use_corr;
               altitude_out      <= alt_d;
               sat_used_out      <= use_corr ? (qual & sat_corr_valid_in) : qual;
            end
         end
      end
   end

   // remember altitude of the last 3D solution for automatic fallback
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         last_alt_q    <= 16'h0000;
         last_alt_ok_q <= 1'b0;
      end else if (epoch_go && emit && fix_d == FMG_FIX_3D) begin
         last_alt_q    <= alt_fix_in;
         last_alt_ok_q <= 1'b1;
      end
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);

   sequence s_wb_req;
      wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in;
   endsequence
   sequence s_ack_pulse;
      wb_ack_out ##1 !wb_ack_out;
   endsequence

   chk_ack_timing: assert property (s_wb_req ##1 ce_in |-> s_ack_pulse)
      else $error("wishbone ack not a single cycle after request");
   chk_elev_mask: assert property (qual[0] |-> sat_elev_in[7:0] >= elev_mask_q)
      else $error("channel 0 used below elevation mask");
   chk_snr_mask: assert property (qual[0] |-> sat_snr_in[7:0] >= snr_mask_q)
      else $error("channel 0 used below signal mask");
   chk_eph_gate: assert property ($past(epoch_go) && report_valid_out
                                  |-> $past(eph_ok) && $past(nsel) >= 4'h3)
      else $error("report without orbital data or qualifying set");
   chk_forced_two_dim: assert property ($past(epoch_go) && report_valid_out
      && $past(fix_mode_q) == FMG_FORCED_TWO_DIM_FIX |-> !fix_three_dim_out)
      else $error("3D report in forced 2D mode");
   chk_forced_three_dim: assert property ($past(epoch_go) && report_valid_out
      && $past(fix_mode_q) == FMG_FORCED_THREE_DIM_FIX
      |-> fix_three_dim_out && $past(nsel) >= 4'h4)
      else $error("forced 3D report without four satellites");
   chk_auto_switch: assert property ($past(epoch_go) && report_valid_out
      && $past(fix_mode_q) == FMG_AUTO_DIM_FIX && $past(pdop_in) > $past(sw_thr_q)
      && $past(hdop_in) < $past(dop_mask_q) |-> !fix_three_dim_out)
      else $error("automatic mode kept 3D above switch threshold");
   chk_diff_on: assert property ($past(epoch_go) && $past(diff_mode_q)
      == FMG_CORRECTION_FORCED_ON && !$past(corr_data_ok_in) |-> !report_valid_out)
      else $error("report without corrections in forced correction mode");
   chk_diff_off: assert property ($past(epoch_go) && report_valid_out
      && $past(diff_mode_q) == FMG_CORRECTION_FORCED_OFF |-> !corrected_out)
      else $error("corrected report in correction off mode");
   chk_epoch_gap: assert property (report_valid_out && ce_in |=> !report_valid_out)
      else $error("reports closer than one epoch");
endmodule
`default_nettype wire

/* File: verification/fmg_partner.sv */
// Purpose: tracking channels and correction source beside the block
// Assumes: eight channels; bench picks the sky picture through plain inputs
// Notes:   the two top channels are always locked but fail one mask each
`timescale 1ns/1ps
`default_nettype none
module fmg_partner #(
   parameter int N = 8
) (
   // sky picture chosen by the bench
   input  wire logic [3:0]     ngood_in,
   input  wire logic           eph_ok_in,
   input  wire logic           corr_ok_in,
   // channel state towards the block
   output logic      [N*8-1:0] elev_out,
   output logic      [N*8-1:0] snr_out,
   output logic      [N-1:0]   locked_out,
   output logic      [N-1:0]   eph_out,
   output logic      [N-1:0]   corr_out,
   output logic                corr_data_ok_out
);
   // good channels sit exactly on the default masks, spare ones are unlocked except the top two
   always_comb begin
      for (int i = 0; i < N; i++) begin
         elev_out[i*8 +: 8] = (i < int'(ngood_in)) ? 8'h05 : 8'h1E;
         snr_out[i*8 +: 8]  = (i < int'(ngood_in)) ? 8'h02 : 8'h1E;
         locked_out[i]      = (i < int'(ngood_in)) || (i >= N - 2);
      end
      // one locked channel just under elevation, one just under signal quality
      elev_out[(N-2)*8 +: 8] = 8'h04;
      snr_out[(N-1)*8 +: 8]  = 8'h01;
      eph_out                = {{(N-1){1'b1}}, eph_ok_in};
      corr_out               = {N{1'b1}};
      corr_data_ok_out       = corr_ok_in;
   end
endmodule
`default_nettype wire

/* File: verification/fmg_top_bench.sv */
// Purpose: self-checking bench for fix mode choice and report gating
// Assumes: epoch shortened to 16 cycles; ce_in held high except during s_freeze
// Notes:   every sky picture is held 52 cycles so the 32-cycle window spans two epochs
`timescale 1ns/1ps
`default_nettype none
module fmg_top_bench;
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic [3:0]  ngood = 4'h3;
   logic        eph_ok = 1'b1, corr_ok = 1'b1;
   logic        ce = 1'b1;
   logic [7:0]  pdop = 8'h04, hdop = 8'h03;
   logic [15:0] alt_fix = 16'h0ABC;
   logic [63:0] elev, snr;
   logic [7:0]  locked, ephv, corrv;
   logic        corr_data_ok;
   logic [31:0] wb_dat_out;
   logic        wb_ack_out, report_valid_out, fix_three_dim_out, corrected_out;
   logic [15:0] altitude_out;
   logic [7:0]  sat_used;
   int          failures = 0;
   int          checks_done = 0;

   // 20 MHz
   always #25 mclk = ~mclk;

   fmg_partner #(.N(8)) far (.ngood_in(ngood), .eph_ok_in(eph_ok), .corr_ok_in(corr_ok),
      .elev_out(elev), .snr_out(snr), .locked_out(locked), .eph_out(ephv), .corr_out(corrv),
      .corr_data_ok_out(corr_data_ok));

   fmg_top #(.N(8), .EPOCH_CYCLES(16)) dut (.mclk_in(mclk), .rstn_in(rstn), .ce_in(ce),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
      .wb_dat_in(wdat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
      .sat_elev_in(elev), .sat_snr_in(snr), .sat_locked_in(locked),
      .sat_eph_valid_in(ephv), .sat_corr_valid_in(corrv), .corr_data_ok_in(corr_data_ok),
      .pdop_in(pdop), .hdop_in(hdop), .alt_fix_in(alt_fix),
      .report_valid_out(report_valid_out), .fix_three_dim_out(fix_three_dim_out),
      .corrected_out(corrected_out), .altitude_out(altitude_out), .sat_used_out(sat_used));

   task automatic report_and_stop;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one classic cycle; ack is sampled at the edge, release follows it
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d);
      int n;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_out !== 1'b1 && n < 20);
      rdat = wb_dat_out;
      if (wb_ack_out !== 1'b1) begin
         failures++;
         report_and_stop();
      end
      cyc <= 1'b0; stb <= 1'b0;
      @(posedge mclk);
   endtask

   // let a decision pass on the new picture, then count reports over two epochs
   task automatic epoch_chk(input int npulse, input logic e3d, input logic ecor,
                            input logic [15:0] ealt);
      int k;
      k = 0;
      repeat (20) @(posedge mclk);
      repeat (32) begin
         @(posedge mclk);
         if (report_valid_out === 1'b1) begin
            k++;
            chk("three_dim", {31'h0, e3d}, {31'h0, fix_three_dim_out});
            chk("corrected", {31'h0, ecor}, {31'h0, corrected_out});
            chk("altitude", {16'h0, ealt}, {16'h0, altitude_out});
            // only the good channels pass both masks; the two bad ones never show
            chk("sat used", (32'h1 << ngood) - 32'h1, {24'h0, sat_used});
         end
      end
      chk("reports per two epochs", npulse, k);
   endtask

   task automatic s_regs;
      wb(1'b0, 8'h04, 4'hF, 32'h0);
      chk("mask reset", 32'h050C_0205, rdat);
      wb(1'b0, 8'h00, 4'hF, 32'h0);
      chk("ctrl reset", 32'h0000_000A, rdat);
      wb(1'b1, 8'h0C, 4'hF, 32'hFFFF_FFFF);
      wb(1'b0, 8'h10, 4'hF, 32'h0);
      chk("unmapped read", 32'h0, rdat);
      // three qualifying, three correctable, no fix yet, orbital data present
      wb(1'b0, 8'h0C, 4'hF, 32'h0);
      chk("stat before fix", 32'h0000_2133, rdat);
   endtask

   task automatic s_auto;
      epoch_chk(2, 1'b0, 1'b1, 16'h0000);
      ngood <= 4'h4;
      epoch_chk(2, 1'b1, 1'b1, 16'h0ABC);
      pdop <= 8'h06;
      epoch_chk(2, 1'b0, 1'b1, 16'h0ABC);
      hdop <= 8'h0C;
      epoch_chk(2, 1'b1, 1'b1, 16'h0ABC);
      hdop <= 8'h03; pdop <= 8'h04; ngood <= 4'h3; alt_fix <= 16'h0DEF;
      epoch_chk(2, 1'b0, 1'b1, 16'h0ABC);
   endtask

   task automatic s_forced;
      wb(1'b1, 8'h00, 4'hF, 32'h0000_0009);
      ngood <= 4'h4; pdop <= 8'h06;
      epoch_chk(2, 1'b1, 1'b1, 16'h0DEF);
      ngood <= 4'h3;
      epoch_chk(0, 1'b0, 1'b0, 16'h0000);
      wb(1'b1, 8'h00, 4'hF, 32'h0000_0008);
      ngood <= 4'h5; pdop <= 8'h02;
      epoch_chk(2, 1'b0, 1'b1, 16'h0000);
      wb(1'b1, 8'h08, 4'hF, 32'h0001_1234);
      epoch_chk(2, 1'b0, 1'b1, 16'h1234);
   endtask

   task automatic s_corr;
      wb(1'b1, 8'h00, 4'hF, 32'h0000_0006);
      ngood <= 4'h4; pdop <= 8'h04;
      epoch_chk(2, 1'b1, 1'b0, 16'h0DEF);
      wb(1'b1, 8'h00, 4'hF, 32'h0000_0002);
      corr_ok <= 1'b0;
      epoch_chk(0, 1'b0, 1'b0, 16'h0000);
      corr_ok <= 1'b1;
      epoch_chk(2, 1'b1, 1'b1, 16'h0DEF);
      wb(1'b1, 8'h00, 4'hF, 32'h0000_000A);
      corr_ok <= 1'b0;
      epoch_chk(2, 1'b1, 1'b0, 16'h0DEF);
      corr_ok <= 1'b1;
      wb(1'b1, 8'h00, 4'hF, 32'h0000_0003);
      epoch_chk(2, 1'b1, 1'b1, 16'h0DEF);
   endtask

   task automatic s_gate;
      eph_ok <= 1'b0;
      epoch_chk(0, 1'b0, 1'b0, 16'h0000);
      eph_ok <= 1'b1;
      wb(1'b1, 8'h00, 4'hF, 32'h0000_001A);
      epoch_chk(0, 1'b0, 1'b0, 16'h0000);
      wb(1'b1, 8'h00, 4'hF, 32'h0000_000A);
      // raise only the switch threshold lane
      wb(1'b1, 8'h04, 4'h8, 32'h0800_0000);
      wb(1'b0, 8'h04, 4'hF, 32'h0);
      chk("mask after lane write", 32'h080C_0205, rdat);
      pdop <= 8'h06;
      epoch_chk(2, 1'b1, 1'b1, 16'h0DEF);
      ngood <= 4'h2;
      epoch_chk(0, 1'b0, 1'b0, 16'h0000);
   endtask

   // low clock enable for 40 cycles: a fixable sky must not reach the outputs
   task automatic s_freeze;
      ce <= 1'b0; ngood <= 4'h4; alt_fix <= 16'h0123;
      repeat (40) begin
         @(posedge mclk);
         chk("frozen report", 32'h0, {31'h0, report_valid_out});
         chk("frozen altitude", 32'h0000_0DEF, {16'h0, altitude_out});
      end
      ce <= 1'b1;
      epoch_chk(2, 1'b1, 1'b1, 16'h0123);
   endtask

   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (6000) @(posedge mclk);
      failures++;
      report_and_stop();
   end

   // main sequence
   initial begin
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      s_regs();
      s_auto();
      s_forced();
      s_corr();
      s_gate();
      s_freeze();
      report_and_stop();
   end
endmodule
`default_nettype wire
